// [common/time_tag_pkg.sv]
// Package: register map, field layout, widths and timing constants of the time tag counter
package time_tag_pkg;

    // Register bus widths and time count width
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int COUNT_W = 64;

    // Clock period in ns and default tick step in ns
    localparam int CLK_PERIOD_NS = 10;
    localparam int STEP_NS_DEFAULT = CLK_PERIOD_NS;
    // Clock cycles between ticks, derived from step and clock period
    localparam int TICK_CYCLES_DEFAULT = (STEP_NS_DEFAULT + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] OFS_CMD        = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_STEP       = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_LIVE_LO    = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_LIVE_HI    = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_CAPT_LO    = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_CAPT_HI    = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_STATUS     = 8'h18;

    // Command register bit positions
    localparam int CMD_CLEAR_BIT   = 0;
    localparam int CMD_CAPTURE_BIT = 1;
    // Status register bit positions
    localparam int STS_CAPT_VALID_BIT = 0;

    // Reset values
    localparam logic [COUNT_W-1:0] COUNT_RESET = 64'h0000_0000_0000_0000;
    localparam logic [DATA_W-1:0]  READ_ZERO   = 32'h0000_0000;

    // Register bus request carried as one bundle
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } bus_req_s;

endpackage : time_tag_pkg

// [design/tick_gen.sv]
// Tick generator: one-cycle tick every TICK_CYCLES enabled clocks
`timescale 1ns/1ps
module tick_gen #(
    parameter int TICK_CYCLES = time_tag_pkg::TICK_CYCLES_DEFAULT
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic arst_n,
    input  wire logic clk_en,
    // Restart and tick
    input  wire logic restart,
    output logic      tick
);
    localparam int CW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
    localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

    logic [CW-1:0] div_reg;

    // Divider counter, restarted by clear
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            div_reg <= '0;
        end else if (clk_en) begin
            if (restart || div_reg == LAST) begin
                div_reg <= '0;
            end else begin
                div_reg <= div_reg + CW'(1);
            end
        end
    end

    // Tick on the last count of each period
    assign tick = clk_en && !restart && (div_reg == LAST);
endmodule : tick_gen

// [design/time_tag_counter.sv]
// Device time tag counter: live ns count, clear and capture commands, register port
// Notes on behaviour
// - Live count readable whenever clk_en is high, in ns
// - One counter feeds all tag outputs
// - Each tick adds resolution in ns
// - Clear command returns counter to start
// - Counting resumes by itself after clear
// - Capture copies live count, counter runs on
// - Held value readable, kept until next capture
// - Held value uses same ns scaling
`timescale 1ns/1ps
module time_tag_counter #(
    parameter int COUNT_W     = time_tag_pkg::COUNT_W,
    parameter int STEP_NS     = time_tag_pkg::STEP_NS_DEFAULT,
    parameter int TICK_CYCLES = time_tag_pkg::TICK_CYCLES_DEFAULT
) (
    // Clock, reset and enable
    input  wire logic                              sys_clk,
    input  wire logic                              arst_n,
    input  wire logic                              clk_en,
    // Register port
    input  wire logic [time_tag_pkg::ADDR_W-1:0]   addr,
    input  wire logic [time_tag_pkg::DATA_W-1:0]   wdata,
    input  wire logic                              wr_stb,
    input  wire logic                              rd_stb,
    output logic      [time_tag_pkg::DATA_W-1:0]   rdata,
    // Shared time base for image, chunk and event tagging
    output logic      [COUNT_W-1:0]                time_tag,
    output logic                                   capture_valid
);
    time_tag_pkg::bus_req_s req;

    logic [COUNT_W-1:0]              count_reg;
    logic [COUNT_W-1:0]              count_next;
    logic [COUNT_W-1:0]              captured_time_count;
    logic [time_tag_pkg::DATA_W-1:0] step_reg;
    logic [time_tag_pkg::DATA_W-1:0] rdata_next;
    logic                            capt_valid_reg;
    logic                            time_count_clear_cmd;
    logic                            time_count_capture_cmd;
    logic                            tick;

    // Bundle the bus request
    assign req.wr    = wr_stb;
    assign req.rd    = rd_stb;
    assign req.addr  = addr;
    assign req.wdata = wdata;

    // Command decode: write-one pulses
    assign time_count_clear_cmd   = clk_en && req.wr && (req.addr == time_tag_pkg::OFS_CMD)
                                    && req.wdata[time_tag_pkg::CMD_CLEAR_BIT];
    assign time_count_capture_cmd = clk_en && req.wr && (req.addr == time_tag_pkg::OFS_CMD)
                                    && req.wdata[time_tag_pkg::CMD_CAPTURE_BIT];

    // Tick source, restarted by clear
    tick_gen #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .clk_en  (clk_en),
        .restart (time_count_clear_cmd),
        .tick    (tick)
    );

    // Step register, resolution in ns per tick
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            step_reg <= time_tag_pkg::DATA_W'(STEP_NS);
        end else if (clk_en && req.wr && req.addr == time_tag_pkg::OFS_STEP) begin
            step_reg <= req.wdata;
        end
    end

    // Next live count
    always_comb begin
        count_next = count_reg;
        if (time_count_clear_cmd) begin
            count_next = time_tag_pkg::COUNT_RESET;
        end else if (tick) begin
            count_next = count_reg + COUNT_W'(step_reg);
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            count_reg <= time_tag_pkg::COUNT_RESET;
        end else if (clk_en) begin
            count_reg <= count_next;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            time_tag <= time_tag_pkg::COUNT_RESET;
        end else if (clk_en) begin
            time_tag <= count_next;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            captured_time_count <= time_tag_pkg::COUNT_RESET;
        end else if (time_count_capture_cmd) begin
            captured_time_count <= count_reg;
        end
    end

    // Capture valid flag, cleared only by reset
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            capt_valid_reg <= 1'b0;
        end else if (time_count_capture_cmd) begin
            capt_valid_reg <= 1'b1;
        end
    end

    assign capture_valid = capt_valid_reg;

    // Read mux
    always_comb begin
        rdata_next = time_tag_pkg::READ_ZERO;
        case (req.addr)
            time_tag_pkg::OFS_STEP:    rdata_next = step_reg;
            time_tag_pkg::OFS_LIVE_LO: rdata_next = count_reg[31:0];
            time_tag_pkg::OFS_LIVE_HI: rdata_next = count_reg[COUNT_W-1:32];
            time_tag_pkg::OFS_CAPT_LO: rdata_next = captured_time_count[31:0];
            time_tag_pkg::OFS_CAPT_HI: rdata_next = captured_time_count[COUNT_W-1:32];
            time_tag_pkg::OFS_STATUS:  rdata_next[time_tag_pkg::STS_CAPT_VALID_BIT] = capt_valid_reg;
            default:                   rdata_next = time_tag_pkg::READ_ZERO;
        endcase
    end

    // Read data register, valid the cycle after the read strobe
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= time_tag_pkg::READ_ZERO;
        end else if (clk_en && req.rd) begin
            rdata <= rdata_next;
        end
    end
endmodule : time_tag_counter

// [verification/time_tag_counter_asserts.sv]
// Checker: port properties of the time tag counter
`timescale 1ns/1ps
module time_tag_counter_asserts #(
    parameter int COUNT_W = 64,
    parameter int STEP_NS = 10
) (
    // Clock, reset, register port
    input wire logic               sys_clk,
    input wire logic               arst_n,
    input wire logic               clk_en,
    input wire logic [7:0]         addr,
    input wire logic [31:0]        wdata,
    input wire logic               wr_stb,
    input wire logic               rd_stb,
    // Outputs
    input wire logic [31:0]        rdata,
    input wire logic [COUNT_W-1:0] time_tag,
    input wire logic               capture_valid
);
    // Accepted read and command write
    wire rd_w  = clk_en && rd_stb;
    wire cmd_w = clk_en && wr_stb && addr == time_tag_pkg::OFS_CMD;
    // Model of the step register, loaded from accepted bus writes
    logic [31:0] step_mdl;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            step_mdl <= 32'(STEP_NS);
        end else if (clk_en && wr_stb && addr == time_tag_pkg::OFS_STEP) begin
            step_mdl <= wdata;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    AST_STEP: assert property ($past(arst_n) && clk_en && !(cmd_w && wdata[0])
        |=> time_tag == COUNT_W'($past(time_tag) + $past(step_mdl))) else $error("count step wrong");
    AST_FREEZE: assert property (!clk_en |=> $stable(time_tag)) else $error("count moved while frozen");
    AST_CLEAR: assert property (cmd_w && wdata[0] |=> time_tag == '0) else $error("clear failed");
    AST_CAPT: assert property (cmd_w && wdata[1] ##1 rd_w && addr == time_tag_pkg::OFS_CAPT_LO
        |=> rdata == 32'($past(time_tag, 2))) else $error("captured value wrong");
    AST_VALID: assert property ((cmd_w && wdata[1]) || capture_valid |=> capture_valid)
        else $error("capture flag wrong");
    AST_NOCAPT: assert property (rd_w && addr == time_tag_pkg::OFS_CAPT_LO && !capture_valid
        |=> rdata == '0) else $error("held value not zero");
    AST_LIVE: assert property (rd_w && addr == time_tag_pkg::OFS_LIVE_LO
        |=> rdata == 32'($past(time_tag))) else $error("live read wrong");
    AST_HOLD: assert property (!rd_w |=> $stable(rdata)) else $error("read data moved");
    // Main scenarios
    cover property (cmd_w && wdata[0]);
    cover property (cmd_w && wdata[1]);
    cover property (!clk_en ##1 clk_en);
endmodule : time_tag_counter_asserts
bind time_tag_counter time_tag_counter_asserts #(.COUNT_W(COUNT_W), .STEP_NS(STEP_NS)) u_time_tag_counter_asserts (
    .sys_clk, .arst_n, .clk_en, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .time_tag, .capture_valid);

// [verification/time_tag_counter_tb.sv]
// Testbench: directed scenarios for the time tag counter
`timescale 1ns/1ps
module time_tag_counter_tb;
    logic        sys_clk = 1'b0;
    logic        arst_n  = 1'b0;
    logic        clk_en  = 1'b1;
    logic [7:0]  addr    = 8'h00;
    logic [31:0] wdata   = 32'h0000_0000;
    logic        wr_stb  = 1'b0;
    logic        rd_stb  = 1'b0;
    logic [31:0] rdata;
    logic [63:0] time_tag;
    logic        capture_valid;
    int          num_errors = 0;
    int          n_compared = 0;
    // Clock at 100 MHz
    always #5 sys_clk = ~sys_clk;
    time_tag_counter u_time_tag_counter (.sys_clk, .arst_n, .clk_en, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
        .time_tag, .capture_valid);
    // Compare and count
    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string name);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // One write cycle
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wr_stb <= 1'b1;
        addr   <= a;
        wdata  <= d;
        @(posedge sys_clk);
        wr_stb <= 1'b0;
        #1;
    endtask : wr
    // One read cycle, data judged in the next cycle
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        rd_stb <= 1'b1;
        addr   <= a;
        @(posedge sys_clk);
        rd_stb <= 1'b0;
        #1;
        check(64'(rdata), 64'(exp), $sformatf("rdata at %h", a));
    endtask : rd
    // Reset values, default step, unmapped read
    task automatic t_reset();
        rd(time_tag_pkg::OFS_CAPT_LO, 32'h0000_0000);
        rd(time_tag_pkg::OFS_STATUS, 32'h0000_0000);
        rd(time_tag_pkg::OFS_STEP, 32'(time_tag_pkg::STEP_NS_DEFAULT));
        rd(8'h1C, 32'h0000_0000);
    endtask : t_reset
    // Clear, restart, capture, capture together with clear
    task automatic t_capture();
        wr(time_tag_pkg::OFS_CMD, 32'h0000_0001);
        check(time_tag, 64'h0, "time_tag");
        rd(time_tag_pkg::OFS_LIVE_LO, 32'h0000_0000);
        rd(time_tag_pkg::OFS_LIVE_LO, 32'h0000_000A);
        repeat (2) @(posedge sys_clk);
        wr(time_tag_pkg::OFS_CMD, 32'h0000_0002);
        rd(time_tag_pkg::OFS_CAPT_LO, 32'h0000_0028);
        rd(time_tag_pkg::OFS_CAPT_HI, 32'h0000_0000);
        rd(time_tag_pkg::OFS_STATUS, 32'h0000_0001);
        rd(time_tag_pkg::OFS_LIVE_LO, 32'h0000_0050);
        wr(time_tag_pkg::OFS_CMD, 32'h0000_0003);
        rd(time_tag_pkg::OFS_CAPT_LO, 32'h0000_005A);
        rd(time_tag_pkg::OFS_LIVE_LO, 32'h0000_000A);
        check(64'(capture_valid), 64'h1, "capture_valid");
    endtask : t_capture
    // Frozen enable ignores a clear and holds the count
    task automatic t_freeze();
        clk_en <= 1'b0;
        wr(time_tag_pkg::OFS_CMD, 32'h0000_0001);
        repeat (2) @(posedge sys_clk);
        clk_en <= 1'b1;
        rd(time_tag_pkg::OFS_LIVE_LO, 32'h0000_0014);
    endtask : t_freeze
    // New step size takes effect on the following ticks
    task automatic t_step();
        wr(time_tag_pkg::OFS_STEP, 32'h0000_0019);
        rd(time_tag_pkg::OFS_STEP, 32'h0000_0019);
        rd(time_tag_pkg::OFS_LIVE_LO, 32'h0000_0041);
        rd(time_tag_pkg::OFS_LIVE_LO, 32'h0000_005A);
        wr(time_tag_pkg::OFS_STEP, 32'(time_tag_pkg::STEP_NS_DEFAULT));
    endtask : t_step
    // Verdict and end of run
    task automatic final_report();
        if (num_errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report
    // Main sequence
    initial begin
        repeat (20) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        #1;
        t_reset();
        t_capture();
        t_freeze();
        t_step();
        final_report();
    end
    // Hang guard
    initial begin
        #100000;
        num_errors++;
        final_report();
    end
endmodule : time_tag_counter_tb
